// ---- sim/dbg_gpio_port_props.sv ----
// Purpose: Port-level assertions for the GPIO port.
// Assumes: One clock domain, reset async active low.
// Notes: Sees only the top ports; attached by bind.
`timescale 1ns/100ps
`default_nettype none
module dbg_gpio_port_props
   import dbg_gpio_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Observed ports
   input wire reg_req_s i_req,
   input wire logic [31:0] o_rdata,
   input wire logic i_stop,
   input wire logic i_drive_enable,
   input wire pad_ctrl_s o_pad,
   input wire alt_drive_s i_alt,
   input wire logic [PORT_W-1:0] o_alt_in
);
   logic [1:0] age_q;
   // Pads settle to reset config on the first edge after release, checked on the second
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0)
      else $error("read data not zero outside answer");
   upper_zero_a: assert property (o_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   unmapped_a: assert property ($past(i_req.rd && i_req.addr == 8'h10)
      |-> o_rdata == 32'h0) else $error("unmapped read not zero");
   stop_off_a: assert property ($past(i_stop && !i_drive_enable)
      |-> (o_pad.oe & ~DBG_OUT_PINS) == 8'h0 && (o_pad.ie & ~IRQ_PINS) == 8'h0)
      else $error("pin enabled in stop without drive");
   dbg_valid_a: assert property ($past(i_stop && !i_drive_enable)
      && o_pad.oe[0] |-> $past(i_alt.valid[0]))
      else $error("debug pin driven with invalid data");
   reset_pads_a: assert property (age_q == 2'h1 && !$past(i_req.wr)
      |-> o_pad.oe == RST_OE && o_pad.ie == RST_IE && o_pad.pu == RST_PU
      && o_pad.pd == RST_PD) else $error("pad config wrong after reset");
   input_gate_a: assert property ((o_alt_in & ~o_pad.ie) == 8'h0)
      else $error("input seen on disabled pin");
   pull_mask_a: assert property ((o_pad.pu & ~MASK_PU) == 8'h0
      && (o_pad.pd & ~MASK_PD) == 8'h0) else $error("missing pull enabled");
endmodule : dbg_gpio_port_props
bind dbg_gpio_port dbg_gpio_port_props i_props (.i_clk(i_clk),
   .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata), .i_stop(i_stop),
   .i_drive_enable(i_drive_enable), .o_pad(o_pad), .i_alt(i_alt),
   .o_alt_in(o_alt_in));
`default_nettype wire

// ---- sim/debug_shared_gpio_port_test.sv ----
// Purpose: Register and pad tests for the GPIO port.
// Assumes: Register port answers reads one cycle later.
// Notes: Port data reads skip reset since bit 0 carries debug data.
`timescale 1ns/100ps
`default_nettype none
module debug_shared_gpio_port_test;
   import dbg_gpio_pkg::*;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   reg_req_s req = '0;
   logic stop = 1'b0;
   logic drive_en = 1'b0;
   logic valid = 1'b0;
   logic [7:0] level;
   logic [31:0] rdata;
   pad_ctrl_s pad;
   alt_drive_s alt;
   int fail_count = 0;
   int cmp_count = 0;
   logic [7:0] ofs [5] = '{OFS_OUTPUT_ENABLE, OFS_FUNCTION_SELECT,
      OFS_PULLUP_CONTROL, OFS_PULLDOWN_CONTROL, OFS_INPUT_ENABLE};
   logic [7:0] rst_v [5] = '{8'h01, 8'h03, 8'h01, 8'h02, 8'h03};
   logic [7:0] all_v [5] = '{8'hff, 8'h7f, 8'hfd, 8'h02, 8'hff};
   dbg_gpio_port i_dbg_gpio_port (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_req(req), .o_rdata(rdata), .i_stop(stop), .i_drive_enable(drive_en),
      .i_pad(level), .o_pad(pad), .i_alt(alt), .o_alt_in());
   pad_partner i_pad_partner (.i_clk(i_clk), .i_ctl(pad), .i_ext(8'h3c),
      .i_valid(valid), .o_level(level), .o_alt(alt));
   initial forever #50 i_clk = ~i_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      req.rd <= 1'b0;
      #1 chk(rdata, {24'h0, e});
   endtask : rd
   task automatic stp(input logic s, d, v, input logic [7:0] oe, ie);
      @(posedge i_clk);
      stop <= s;
      drive_en <= d;
      valid <= v;
      repeat (3) @(posedge i_clk);
      #1 chk({24'h0, pad.oe}, {24'h0, oe});
      chk({24'h0, pad.ie}, {24'h0, ie});
   endtask : stp
   task automatic do_reset();
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1'b1;
      stp(1'b0, 1'b0, 1'b0, 8'h01, 8'h03);
      chk({pad.pu, pad.pd}, {8'h01, 8'h02});
      for (int k = 0; k < 5; k++) rd(ofs[k], rst_v[k]);
   endtask : do_reset
   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3000) @(posedge i_clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      do_reset();
      for (int k = 0; k < 5; k++) wr(ofs[k], 32'hffff_ffff);
      for (int k = 0; k < 5; k++) rd(ofs[k], all_v[k]);
      rd(8'h10, 8'h00);
      wr(OFS_FUNCTION_SELECT, 32'h0);
      wr(OFS_PULLUP_CONTROL, 32'h0);
      wr(OFS_PORT_DATA, 32'h1a5);
      stp(1'b0, 1'b0, 1'b0, 8'hff, 8'hff);
      chk({24'h0, pad.out}, 32'ha5);
      rd(OFS_PORT_DATA, 8'ha5);
      wr(OFS_OUTPUT_ENABLE, 32'hf0);
      wr(OFS_INPUT_ENABLE, 32'h0f);
      stp(1'b0, 1'b0, 1'b0, 8'hf0, 8'h0f);
      rd(OFS_PORT_DATA, 8'h0c);
      wr(OFS_OUTPUT_ENABLE, 32'hff);
      wr(OFS_FUNCTION_SELECT, 32'h01);
      stp(1'b1, 1'b0, 1'b1, 8'h01, 8'h00);
      stp(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
      stp(1'b1, 1'b1, 1'b0, 8'hfe, 8'h0f);
      stp(1'b1, 1'b1, 1'b1, 8'hff, 8'h0f);
      stp(1'b0, 1'b0, 1'b0, 8'hff, 8'h0f);
      do_reset();
      give_verdict();
   end
endmodule : debug_shared_gpio_port_test
`default_nettype wire

// ---- sim/pad_partner.sv ----
// Purpose: Pads and debug logic on the far side of the port.
// Assumes: An external source drives pins nobody else drives.
// Notes: Debug data changes every cycle so stale values show.
`timescale 1ns/100ps
`default_nettype none
module pad_partner
   import dbg_gpio_pkg::*;
(
   input wire logic i_clk,
   input wire pad_ctrl_s i_ctl,
   input wire logic [PORT_W-1:0] i_ext,
   input wire logic i_valid,
   output logic [PORT_W-1:0] o_level,
   output alt_drive_s o_alt
);
   logic [PORT_W-1:0] pat_q = 8'h55;
   always_ff @(posedge i_clk) pat_q <= ~pat_q;
   // Wire level: port drive, then pull-up, then pull-down
   assign o_level = (i_ctl.oe & i_ctl.out)
      | (~i_ctl.oe & (i_ctl.pu | (~i_ctl.pd & i_ext)));
   assign o_alt = '{out: pat_q, oe: 8'h01, valid: {7'h0, i_valid}};
endmodule : pad_partner
`default_nettype wire

// ---- src/dbg_gpio_pkg.sv ----
// Purpose: Constants and carrier types for the debug-shared GPIO port.
// Assumes: One 10 MHz clock, word-aligned register offsets.
// Notes: How the block behaves is listed below.
//
// How it works
// - Eight bits, each with its own output enable.
// - Function select 1 routes the pin to debug or trace logic.
// - Open-drain control is not implemented; no pin is OD_CAPABLE, so its bits stay zero.
// - General-purpose input enables reset to zero.
// - Stop with drive enable 1 keeps the register enables, except bit 0 debug output.
// - Stop with drive enable 0 turns ordinary pin input and output off.
// - Bit 0 debug output stays on in stop whatever drive enable says.
// - Debug output in stop drives only while debug data is valid.
// - Interrupt pins keep input in stop; output follows drive enable.
// - Reset: bit 0 is debug data with input, output, pull-up on.
// - Reset: bit 1 is debug clock with input and pull-down on.
// - Reset: bits 2 to 7 are port bits, all enables off.
// - Registers at base 0x4000_0000 with the listed offsets.
// - Data holds bits 7-0, reset zero, upper bits read zero.
// - Output enable 1 drives; reset leaves only bit 0 set.
// - Function select bits 6-0 only, reset with bits 1 and 0.
// - Pull-up bits switch each pin's pull-up except bit 1, which has none.
// - Pull-down bit 1 switches the only pull-down, on bit 1.
// - Input needs the input-enable bit; output enable is not enough.

package dbg_gpio_pkg;

   localparam int unsigned PORT_W = 8;
   localparam int unsigned ADDR_W = 8;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [31:0] PORT_BASE = 32'h4000_0000;
   localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_ENABLE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FUNCTION_SELECT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PULLUP_CONTROL = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_PULLDOWN_CONTROL = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_INPUT_ENABLE = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN_CONTROL = 8'h3c;

   // ----------------------------------------------------------------
   // Reset values and implemented-bit masks
   // ----------------------------------------------------------------
   localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
   localparam logic [PORT_W-1:0] RST_OE = 8'h01;
   localparam logic [PORT_W-1:0] RST_FSEL = 8'h03;
   localparam logic [PORT_W-1:0] RST_PU = 8'h01;
   localparam logic [PORT_W-1:0] RST_PD = 8'h02;
   localparam logic [PORT_W-1:0] RST_IE = 8'h03;
   localparam logic [PORT_W-1:0] RST_OD = 8'h00;
   localparam logic [PORT_W-1:0] MASK_FSEL = 8'h7f;
   localparam logic [PORT_W-1:0] MASK_PU = 8'hfd;
   localparam logic [PORT_W-1:0] MASK_PD = 8'h02;
   // Pins whose alternate function is an external interrupt input
   localparam logic [PORT_W-1:0] IRQ_PINS = 8'h00;
   // Pins whose alternate function is a debug output kept alive in stop
   localparam logic [PORT_W-1:0] DBG_OUT_PINS = 8'h01;
   localparam logic [PORT_W-1:0] OD_CAPABLE = 8'h00;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] valid;
   } alt_drive_s;

   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] pu;
      logic [PORT_W-1:0] pd;
      logic [PORT_W-1:0] ie;
   } pad_ctrl_s;

endpackage : dbg_gpio_pkg

// ---- src/dbg_gpio_port.sv ----
// Purpose: Eight-bit GPIO port shared with debug and trace functions.
// Assumes: Pad inputs are asynchronous; alternate logic is on i_clk.
// Notes: All outputs are registered, so pads lag controls by one cycle.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module dbg_gpio_port
   import dbg_gpio_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire reg_req_s i_req,
   output logic [31:0] o_rdata,
   // Low-power state
   input wire logic i_stop,
   input wire logic i_drive_enable,
   // Pads
   input wire logic [PORT_W-1:0] i_pad,
   output var pad_ctrl_s o_pad,
   // Alternate function side
   input wire alt_drive_s i_alt,
   output logic [PORT_W-1:0] o_alt_in
);

   typedef struct packed {
      logic [PORT_W-1:0] data;
      logic [PORT_W-1:0] oe;
      logic [PORT_W-1:0] fsel;
      logic [PORT_W-1:0] pu;
      logic [PORT_W-1:0] pd;
      logic [PORT_W-1:0] ie;
      logic [PORT_W-1:0] od;
      logic [PORT_W-1:0] sync1;
      logic [PORT_W-1:0] sync2;
      logic [31:0] rdata;
      pad_ctrl_s pad;
      logic [PORT_W-1:0] alt_in;
   } state_s;

   state_s st_q;
   state_s st_d;

   logic [PORT_W-1:0] in_en;
   logic [PORT_W-1:0] drv_en;
   logic [PORT_W-1:0] drv_val;
   logic [PORT_W-1:0] wv;

   // ----------------------------------------------------------------
   // Pad steering
   // ----------------------------------------------------------------
   always_comb begin
      for (int b = 0; b < PORT_W; b++) begin
         in_en[b] = st_q.ie[b];
         drv_val[b] = st_q.fsel[b] ? i_alt.out[b] : st_q.data[b];
         drv_en[b] = st_q.oe[b] && (!st_q.fsel[b] || i_alt.oe[b]);
         if (i_stop) begin
            if (st_q.fsel[b] && DBG_OUT_PINS[b] && st_q.oe[b]) begin
               drv_en[b] = i_alt.valid[b];
               in_en[b] = in_en[b] && i_drive_enable;
            end else if (st_q.fsel[b] && IRQ_PINS[b] && st_q.ie[b]) begin
               drv_en[b] = drv_en[b] && i_drive_enable;
            end else if (!i_drive_enable) begin
               in_en[b] = 1'b0;
               drv_en[b] = 1'b0;
            end
         end
         if (st_q.od[b] && OD_CAPABLE[b]) begin
            drv_en[b] = drv_en[b] && !drv_val[b];
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      wv = i_req.wdata[PORT_W-1:0];
      // Second stage only reads the first; logic reads stage two
      st_d.sync1 = i_pad;
      st_d.sync2 = st_q.sync1;
      if (i_req.wr) begin
         unique case (i_req.addr)
            OFS_PORT_DATA: st_d.data = wv;
            OFS_OUTPUT_ENABLE: st_d.oe = wv;
            OFS_FUNCTION_SELECT: st_d.fsel = wv & MASK_FSEL;
            OFS_PULLUP_CONTROL: st_d.pu = wv & MASK_PU;
            OFS_PULLDOWN_CONTROL: st_d.pd = wv & MASK_PD;
            OFS_INPUT_ENABLE: st_d.ie = wv;
            OFS_OPEN_DRAIN_CONTROL: st_d.od = wv & OD_CAPABLE;
            default: ;
         endcase
      end
      st_d.rdata = 32'h0000_0000;
      if (i_req.rd) begin
         unique case (i_req.addr)
            OFS_PORT_DATA: st_d.rdata[PORT_W-1:0] = st_q.sync2 & in_en;
            OFS_OUTPUT_ENABLE: st_d.rdata[PORT_W-1:0] = st_q.oe;
            OFS_FUNCTION_SELECT: st_d.rdata[PORT_W-1:0] = st_q.fsel;
            OFS_PULLUP_CONTROL: st_d.rdata[PORT_W-1:0] = st_q.pu;
            OFS_PULLDOWN_CONTROL: st_d.rdata[PORT_W-1:0] = st_q.pd;
            OFS_INPUT_ENABLE: st_d.rdata[PORT_W-1:0] = st_q.ie;
            OFS_OPEN_DRAIN_CONTROL: st_d.rdata[PORT_W-1:0] = st_q.od;
            default: ;
         endcase
      end
      st_d.pad.out = drv_val;
      st_d.pad.oe = drv_en;
      st_d.pad.pu = st_q.pu;
      st_d.pad.pd = st_q.pd;
      st_d.pad.ie = in_en;
      // Alternate logic sees the pin only when input is enabled
      st_d.alt_in = st_q.sync2 & in_en & st_q.fsel;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= '0;
         st_q.data <= RST_DATA;
         st_q.oe <= RST_OE;
         st_q.fsel <= RST_FSEL;
         st_q.pu <= RST_PU;
         st_q.pd <= RST_PD;
         st_q.ie <= RST_IE;
         st_q.od <= RST_OD;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_rdata = st_q.rdata;
   assign o_pad = st_q.pad;
   assign o_alt_in = st_q.alt_in;

endmodule : dbg_gpio_port
`default_nettype wire
